// [core/sgm_regs.sv]
module sgm_regs #(
   parameter int ADDR_W = sgm_pkg::ADDR_W,
   parameter int ACC_W = sgm_pkg::ACC_W,
   parameter int RESULT_W = sgm_pkg::RESULT_W
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sync_pin,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic [RESULT_W-1:0] mon_result_a,
   input wire logic [RESULT_W-1:0] mon_result_b,
   output logic mon_sync,
   output logic mon_enable,
   output logic mon_ms_select,
   output logic [1:0] mon_mode,
   output logic mon_complex,
   output logic [23:0] mon_period,
   output logic hb_sync,
   output logic hb_alt_phase,
   output logic hb_spectral_rev,
   output logic hb_high_pass,
   output logic osc_sync,
   output logic [2:0] osc_ctl,
   output logic [ACC_W-1:0] osc_phase_acc
);
   logic [7:0] sync_ctl_r;
   logic [7:0] filt_ctl_r;
   logic [7:0] mon_ctl_r;
   logic [7:0] osc_ctl_r;
   logic [23:0] period_r;
   logic [31:0] freq_r;
   logic [15:0] phase_r;
   logic [ACC_W-1:0] acc_r;
   logic [7:0] rdata_r;
   logic rvalid_r;
   logic mon_sync_r;
   logic hb_sync_r;
   logic osc_sync_r;
   logic master;
   logic mon_fire;
   logic hb_fire;
   logic osc_fire;
   logic ctl_wr;

   sgm_sync_if ev ();

   sgm_sync_edge u_edge (
      .clock(clock),
      .nrst(nrst),
      .sync_pin(sync_pin),
      .ev(ev)
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [12:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   assign ctl_wr = reg_wr && hit(reg_addr, sgm_pkg::OFS_SYNC_CTL);
   assign master = sync_ctl_r[sgm_pkg::SYNC_MASTER];

   // Each gate qualifies one edge event with its own enable and the master bit
   assign mon_fire = ev.rise && master && sync_ctl_r[sgm_pkg::SYNC_MON_EN];
   assign hb_fire = ev.rise && master && sync_ctl_r[sgm_pkg::SYNC_HB_EN];
   assign osc_fire = ev.rise && master && sync_ctl_r[sgm_pkg::SYNC_OSC_EN];

   // Sync control: a host write in the same cycle as a first-only clear
   // wins, so a freshly armed enable is never lost.
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         sync_ctl_r <= sgm_pkg::RST_BYTE;
      end else if (ctl_wr) begin
         sync_ctl_r <= reg_wdata & sgm_pkg::SYNC_CTL_MASK;
      end else begin
         if (hb_fire && sync_ctl_r[sgm_pkg::SYNC_HB_ONCE]) begin
            sync_ctl_r[sgm_pkg::SYNC_HB_EN] <= 1'b0;
         end
         if (osc_fire && sync_ctl_r[sgm_pkg::SYNC_OSC_ONCE]) begin
            sync_ctl_r[sgm_pkg::SYNC_OSC_EN] <= 1'b0;
         end
      end
   end

   // Plain read/write configuration registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         filt_ctl_r <= sgm_pkg::RST_FILT_CTL;
         mon_ctl_r <= sgm_pkg::RST_BYTE;
         osc_ctl_r <= sgm_pkg::RST_BYTE;
      end else if (reg_wr) begin
         if (hit(reg_addr, sgm_pkg::OFS_FILT_CTL)) begin
            filt_ctl_r <= reg_wdata & sgm_pkg::FILT_CTL_MASK;
         end
         if (hit(reg_addr, sgm_pkg::OFS_MON_CTL)) begin
            mon_ctl_r <= reg_wdata & sgm_pkg::MON_CTL_MASK;
         end
         if (hit(reg_addr, sgm_pkg::OFS_OSC_CTL)) begin
            osc_ctl_r <= reg_wdata & sgm_pkg::OSC_CTL_MASK;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         period_r <= {3{sgm_pkg::RST_BYTE}};
      end else if (reg_wr) begin
         if (hit(reg_addr, sgm_pkg::OFS_MON_PER0)) begin
            period_r[7:0] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_MON_PER1)) begin
            period_r[15:8] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_MON_PER2)) begin
            period_r[23:16] <= reg_wdata;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         freq_r <= {4{sgm_pkg::RST_BYTE}};
         phase_r <= {2{sgm_pkg::RST_BYTE}};
      end else if (reg_wr) begin
         if (hit(reg_addr, sgm_pkg::OFS_FREQ0)) begin
            freq_r[7:0] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_FREQ1)) begin
            freq_r[15:8] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_FREQ2)) begin
            freq_r[23:16] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_FREQ3)) begin
            freq_r[31:24] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_PHASE0)) begin
            phase_r[7:0] <= reg_wdata;
         end
         if (hit(reg_addr, sgm_pkg::OFS_PHASE1)) begin
            phase_r[15:8] <= reg_wdata;
         end
      end
   end

   // Registered sync pulses to the target blocks
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         mon_sync_r <= 1'b0;
         hb_sync_r <= 1'b0;
         osc_sync_r <= 1'b0;
      end else begin
         mon_sync_r <= mon_fire;
         hb_sync_r <= hb_fire;
         osc_sync_r <= osc_fire;
      end
   end

   // Phase accumulator; the offset sits in the top bits so a reload
   // lands on the programmed phase exactly
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         acc_r <= '0;
      end else if (osc_fire) begin
         acc_r <= {phase_r, (ACC_W - 16)'(0)};
      end else if (osc_ctl_r[sgm_pkg::OSC_ENABLE]) begin
         acc_r <= acc_r + ACC_W'(freq_r);
      end
   end

   // Register readback, one cycle after the read strobe
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= 8'h00;
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               ADDR_W'(sgm_pkg::OFS_SYNC_CTL): rdata_r <= sync_ctl_r;
               ADDR_W'(sgm_pkg::OFS_FILT_CTL): rdata_r <= filt_ctl_r | sgm_pkg::FILT_CTL_FIXED;
               ADDR_W'(sgm_pkg::OFS_MON_CTL): rdata_r <= mon_ctl_r;
               ADDR_W'(sgm_pkg::OFS_MON_PER0): rdata_r <= period_r[7:0];
               ADDR_W'(sgm_pkg::OFS_MON_PER1): rdata_r <= period_r[15:8];
               ADDR_W'(sgm_pkg::OFS_MON_PER2): rdata_r <= period_r[23:16];
               ADDR_W'(sgm_pkg::OFS_RES_A0): rdata_r <= mon_result_a[7:0];
               ADDR_W'(sgm_pkg::OFS_RES_A1): rdata_r <= mon_result_a[15:8];
               ADDR_W'(sgm_pkg::OFS_RES_A2): rdata_r <= {4'h0, mon_result_a[19:16]};
               ADDR_W'(sgm_pkg::OFS_RES_B0): rdata_r <= mon_result_b[7:0];
               ADDR_W'(sgm_pkg::OFS_RES_B1): rdata_r <= mon_result_b[15:8];
               ADDR_W'(sgm_pkg::OFS_RES_B2): rdata_r <= {4'h0, mon_result_b[19:16]};
               ADDR_W'(sgm_pkg::OFS_OSC_CTL): rdata_r <= osc_ctl_r;
               ADDR_W'(sgm_pkg::OFS_FREQ0): rdata_r <= freq_r[7:0];
               ADDR_W'(sgm_pkg::OFS_FREQ1): rdata_r <= freq_r[15:8];
               ADDR_W'(sgm_pkg::OFS_FREQ2): rdata_r <= freq_r[23:16];
               ADDR_W'(sgm_pkg::OFS_FREQ3): rdata_r <= freq_r[31:24];
               ADDR_W'(sgm_pkg::OFS_PHASE0): rdata_r <= phase_r[7:0];
               ADDR_W'(sgm_pkg::OFS_PHASE1): rdata_r <= phase_r[15:8];
               default: rdata_r <= 8'h00;
            endcase
         end
      end
   end

   assign reg_rdata = rdata_r;
   assign reg_rvalid = rvalid_r;
   assign mon_sync = mon_sync_r;
   assign hb_sync = hb_sync_r;
   assign osc_sync = osc_sync_r;
   assign osc_phase_acc = acc_r;
   assign osc_ctl = osc_ctl_r[2:0];
   assign hb_alt_phase = filt_ctl_r[sgm_pkg::FILT_ALT_PHASE];
   assign hb_spectral_rev = filt_ctl_r[2];
   assign hb_high_pass = filt_ctl_r[1];
   assign mon_ms_select = mon_ctl_r[sgm_pkg::MON_MS_SEL];
   assign mon_mode = mon_ctl_r[2:1];
   assign mon_enable = mon_ctl_r[0];
   assign mon_complex = mon_ctl_r[7];
   assign mon_period = period_r;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence hb_fire_s;
      ev.rise && sync_ctl_r[sgm_pkg::SYNC_MASTER] && sync_ctl_r[sgm_pkg::SYNC_HB_EN];
   endsequence

   sequence osc_fire_s;
      ev.rise && sync_ctl_r[sgm_pkg::SYNC_MASTER] && sync_ctl_r[sgm_pkg::SYNC_OSC_EN];
   endsequence

   sequence mon_fire_s;
      ev.rise && sync_ctl_r[sgm_pkg::SYNC_MASTER] && sync_ctl_r[sgm_pkg::SYNC_MON_EN];
   endsequence

   sequence no_ctl_wr_s;
      !(reg_wr && reg_addr == ADDR_W'(sgm_pkg::OFS_SYNC_CTL));
   endsequence

   // Free-running step: no reload pending and accumulation switched on
   sequence acc_run_s;
      !osc_fire && osc_ctl_r[sgm_pkg::OSC_ENABLE];
   endsequence

   mon_gate_a: assert property (
      mon_sync_r |-> $past(ev.rise) && $past(sync_ctl_r[7]) && $past(sync_ctl_r[0]))
      else $error("monitor sync without both enables");

   hb_pulse_a: assert property (
      hb_fire_s |=> hb_sync_r ##1 !hb_sync_r)
      else $error("half-band sync not forwarded as one pulse");

   hb_once_a: assert property (
      hb_fire_s ##0 sync_ctl_r[6] ##0 no_ctl_wr_s |=> !sync_ctl_r[5])
      else $error("half-band first-only enable not cleared");

   cont_keep_a: assert property (
      hb_fire_s ##0 !sync_ctl_r[6] ##0 no_ctl_wr_s |=> sync_ctl_r[5])
      else $error("continuous half-band enable lost");

   osc_once_a: assert property (
      osc_fire_s ##0 sync_ctl_r[4] ##0 no_ctl_wr_s |=> !sync_ctl_r[3] && osc_sync_r)
      else $error("oscillator first-only enable not cleared");

   osc_reload_a: assert property (
      osc_fire_s |=> acc_r == {$past(phase_r), 16'h0000})
      else $error("accumulator not reloaded with phase offset");

   osc_gate_a: assert property (
      osc_sync_r |-> $past(sync_ctl_r[3]) && $past(sync_ctl_r[0]))
      else $error("oscillator sync without both enables");

   master_off_a: assert property (
      !sync_ctl_r[0] |=> !mon_sync_r && !hb_sync_r && !osc_sync_r)
      else $error("sync passed with master enable low");

   res_a_top_a: assert property (
      reg_rd && reg_addr == ADDR_W'(sgm_pkg::OFS_RES_A2)
         |=> reg_rvalid && rdata_r == {4'h0, $past(mon_result_a[19:16])})
      else $error("channel A top result byte wrong");

   res_b_low_a: assert property (
      reg_rd && reg_addr == ADDR_W'(sgm_pkg::OFS_RES_B0) |=> rdata_r == $past(mon_result_b[7:0]))
      else $error("channel B low result byte wrong");

   edge_once_a: assert property (
      ev.rise |=> !ev.rise)
      else $error("two sync events from one edge");

   mon_pulse_a: assert property (
      mon_fire_s |=> mon_sync_r ##1 !mon_sync_r)
      else $error("monitor sync not forwarded as one pulse");

   osc_pulse_a: assert property (
      osc_fire_s |=> osc_sync_r ##1 !osc_sync_r)
      else $error("oscillator sync not forwarded as one pulse");

   osc_keep_a: assert property (
      osc_fire_s ##0 !sync_ctl_r[sgm_pkg::SYNC_OSC_ONCE] ##0 no_ctl_wr_s
         |=> sync_ctl_r[sgm_pkg::SYNC_OSC_EN])
      else $error("continuous oscillator enable lost");

   hb_gate_a: assert property (
      hb_sync_r |-> $past(ev.rise) && $past(sync_ctl_r[sgm_pkg::SYNC_HB_EN])
         && $past(sync_ctl_r[sgm_pkg::SYNC_MASTER]))
      else $error("half-band sync without both enables");

   master_hold_a: assert property (
      !sync_ctl_r[sgm_pkg::SYNC_MASTER] ##0 no_ctl_wr_s |=> $stable(sync_ctl_r))
      else $error("sync control changed with master enable low");

   acc_step_a: assert property (
      acc_run_s |=> acc_r == $past(acc_r) + $past(freq_r))
      else $error("accumulator did not advance by the frequency word");

   acc_hold_a: assert property (
      !osc_fire && !osc_ctl_r[sgm_pkg::OSC_ENABLE] |=> $stable(acc_r))
      else $error("accumulator moved while stopped");

   alt_phase_a: assert property (
      reg_wr && reg_addr == ADDR_W'(sgm_pkg::OFS_FILT_CTL)
         |=> hb_alt_phase == $past(reg_wdata[sgm_pkg::FILT_ALT_PHASE]))
      else $error("decimation phase select not taken from write");

   ms_select_a: assert property (
      reg_wr && reg_addr == ADDR_W'(sgm_pkg::OFS_MON_CTL)
         |=> mon_ms_select == $past(reg_wdata[sgm_pkg::MON_MS_SEL]))
      else $error("power select not taken from write");

   res_a_low_a: assert property (
      reg_rd && reg_addr == ADDR_W'(sgm_pkg::OFS_RES_A0)
         |=> rdata_r == $past(mon_result_a[7:0]))
      else $error("channel A low result byte wrong");

   res_b_top_a: assert property (
      reg_rd && reg_addr == ADDR_W'(sgm_pkg::OFS_RES_B2)
         |=> rdata_r == {4'h0, $past(mon_result_b[19:16])})
      else $error("channel B top result byte wrong");
endmodule

// [core/sgm_pkg.sv]
package sgm_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int ACC_W = 32;
   localparam int PHASE_W = 16;
   localparam int PERIOD_W = 24;
   localparam int RESULT_W = 20;

   localparam logic [12:0] OFS_SYNC_CTL = 13'h0100;
   localparam logic [12:0] OFS_FILT_CTL = 13'h0103;
   localparam logic [12:0] OFS_MON_CTL = 13'h0112;
   localparam logic [12:0] OFS_MON_PER0 = 13'h0113;
   localparam logic [12:0] OFS_MON_PER1 = 13'h0114;
   localparam logic [12:0] OFS_MON_PER2 = 13'h0115;
   localparam logic [12:0] OFS_RES_A0 = 13'h0116;
   localparam logic [12:0] OFS_RES_A1 = 13'h0117;
   localparam logic [12:0] OFS_RES_A2 = 13'h0118;
   localparam logic [12:0] OFS_RES_B0 = 13'h0119;
   localparam logic [12:0] OFS_RES_B1 = 13'h011a;
   localparam logic [12:0] OFS_RES_B2 = 13'h011b;
   localparam logic [12:0] OFS_OSC_CTL = 13'h011d;
   localparam logic [12:0] OFS_FREQ0 = 13'h011e;
   localparam logic [12:0] OFS_FREQ1 = 13'h011f;
   localparam logic [12:0] OFS_FREQ2 = 13'h0120;
   localparam logic [12:0] OFS_FREQ3 = 13'h0121;
   localparam logic [12:0] OFS_PHASE0 = 13'h0122;
   localparam logic [12:0] OFS_PHASE1 = 13'h0123;

   // Sync control field positions
   localparam int SYNC_MASTER = 0;
   localparam int SYNC_OSC_EN = 3;
   localparam int SYNC_OSC_ONCE = 4;
   localparam int SYNC_HB_EN = 5;
   localparam int SYNC_HB_ONCE = 6;
   localparam int SYNC_MON_EN = 7;
   localparam logic [7:0] SYNC_CTL_MASK = 8'hf9;

   localparam int FILT_ALT_PHASE = 3;
   localparam logic [7:0] FILT_CTL_MASK = 8'h0e;
   localparam logic [7:0] FILT_CTL_FIXED = 8'h01;
   localparam int MON_MS_SEL = 3;
   localparam logic [7:0] MON_CTL_MASK = 8'h8f;
   localparam logic [7:0] OSC_CTL_MASK = 8'h07;
   localparam int OSC_ENABLE = 0;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_FILT_CTL = 8'h00;
endpackage

// [core/sgm_sync_if.sv]
interface sgm_sync_if;
   logic rise;
   modport src (output rise);
   modport dst (input rise);
endinterface

// [core/sgm_sync_edge.sv]
// Pin resynchroniser followed by a rising edge detector
module sgm_sync_edge (
   input wire logic clock,
   input wire logic nrst,
   input wire logic sync_pin,
   sgm_sync_if.src ev
);
   logic meta_r;
   logic stable_r;
   logic prev_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r <= 1'b0;
         stable_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         meta_r <= sync_pin;
         stable_r <= meta_r;
         prev_r <= stable_r;
      end
   end

   // One pulse per rising edge, however long the pin stays high
   assign ev.rise = stable_r & ~prev_r;
endmodule

// [verification/sgm_sync_source.sv]
module sgm_sync_source (
   input wire logic clock,
   input wire logic nrst,
   input wire logic fire,
   output logic sync_pin,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned cnt;
   // High and low 3 clocks each, above the 2-clock minimum the pin needs
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cnt <= 0;
      end else if (fire && cnt == 0) begin
         cnt <= 6;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   assign sync_pin = (cnt > 3);
   assign busy = (cnt != 0);
endmodule

// [verification/testbench.sv]
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, nrst, reg_wr, reg_rd, sync_pin, fire, busy, reg_rvalid, mon_sync, mon_enable;
   logic mon_ms_select, mon_complex, hb_sync, hb_alt_phase, hb_spectral_rev, hb_high_pass;
   logic osc_sync, ph_seen, ph_exp;
   logic [12:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   logic [1:0] mon_mode;
   logic [2:0] osc_ctl;
   logic [23:0] mon_period;
   logic [19:0] mon_result_a, mon_result_b;
   logic [31:0] osc_phase_acc, acc_seen;
   logic [7:0] mdl [0:35];
   logic [7:0] ctl_tab [0:7] = '{8'h00, 8'ha8, 8'h81, 8'h21, 8'h09, 8'ha9, 8'h79, 8'hf9};
   int bad_count, comparisons, n_mon, n_hb, n_osc, em, eh, eo;

   sgm_regs i_sgm_regs (.clock, .nrst, .sync_pin, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_rvalid, .mon_result_a, .mon_result_b, .mon_sync, .mon_enable,
      .mon_ms_select, .mon_mode, .mon_complex, .mon_period, .hb_sync, .hb_alt_phase,
      .hb_spectral_rev, .hb_high_pass, .osc_sync, .osc_ctl, .osc_phase_acc);
   sgm_sync_source i_sgm_sync_source (.clock, .nrst, .fire, .sync_pin, .busy);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   always @(posedge clock) begin
      if (mon_sync === 1'b1) n_mon++;
      if (hb_sync === 1'b1) begin
         n_hb++;
         ph_seen = hb_alt_phase;
      end
      if (osc_sync === 1'b1) begin
         n_osc++;
         acc_seen = osc_phase_acc;
      end
   end

   function automatic logic [7:0] wmask(logic [12:0] a);
      case (a)
         13'h100: return 8'hf9;
         13'h103: return 8'h0e;
         13'h112: return 8'h8f;
         13'h11d: return 8'h07;
         13'h113, 13'h114, 13'h115, 13'h11e, 13'h11f: return 8'hff;
         13'h120, 13'h121, 13'h122, 13'h123: return 8'hff;
         default: return 8'h00;
      endcase
   endfunction

   function automatic logic [7:0] rexp(logic [12:0] a);
      if (a >= 13'h116 && a <= 13'h118) return 8'({4'h0, mon_result_a} >> (8 * (a - 13'h116)));
      if (a >= 13'h119 && a <= 13'h11b) return 8'({4'h0, mon_result_b} >> (8 * (a - 13'h119)));
      if (a == 13'h103) return mdl[3] | 8'h01;
      if (a >= 13'h100 && a <= 13'h123) return mdl[a - 13'h100];
      return 8'h00;
   endfunction

   task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_byte(string what, logic [7:0] exp, logic [7:0] got);
      chk_word(what, {24'h0, exp}, {24'h0, got});
   endtask

   task automatic wr(logic [12:0] a, logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      if (wmask(a) != 8'h00) mdl[a - 13'h100] = d & wmask(a);
   endtask

   task automatic rd(logic [12:0] a);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk_byte("read valid", 8'h01, {7'h0, reg_rvalid});
      chk_byte("read data", rexp(a), reg_rdata);
   endtask

   task automatic pulse();
      logic [7:0] c;
      c = mdl[0];
      @(posedge clock);
      chk_byte("source idle", 8'h00, {7'h0, busy});
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      repeat (10) @(posedge clock);
      if (c[0]) begin
         em += c[7];
         eh += c[5];
         eo += c[3];
         if (c[5]) ph_exp = mdl[3][3];
         if (c[6]) mdl[0][5] = 1'b0;
         if (c[4]) mdl[0][3] = 1'b0;
      end
   endtask

   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      bad_count++;
      complete_run();
   end

   initial begin
      void'($urandom(99));
      {nrst, reg_wr, reg_rd, fire, reg_addr, reg_wdata} = '0;
      mon_result_a = 20'($urandom());
      mon_result_b = 20'($urandom());
      foreach (mdl[i]) mdl[i] = 8'h00;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      for (int a = 'h100; a <= 'h124; a++) rd(13'(a));
      // Writes land on read-only and unmapped places too; those must not stick
      for (int a = 'h100; a <= 'h124; a++) wr(13'(a), 8'($urandom()));
      mon_result_a <= 20'($urandom());
      mon_result_b <= 20'($urandom());
      for (int a = 'h100; a <= 'h124; a++) rd(13'(a));
      chk_byte("alt phase", {7'h0, mdl[3][3]}, {7'h0, hb_alt_phase});
      chk_byte("ms select", {7'h0, mdl[18][3]}, {7'h0, mon_ms_select});
      chk_word("period", {8'h0, mdl[21], mdl[20], mdl[19]}, {8'h0, mon_period});
      chk_byte("mon ctl", mdl[18],
         {mon_complex, 3'h0, mon_ms_select, mon_mode, mon_enable});
      chk_byte("filter ctl", mdl[3],
         {4'h0, hb_alt_phase, hb_spectral_rev, hb_high_pass, 1'b0});
      chk_byte("osc ctl", mdl[29], {5'h0, osc_ctl});
      foreach (ctl_tab[k]) begin
         wr(13'h100, ctl_tab[k]);
         wr(13'h103, 8'($urandom()));
         pulse();
         pulse();
         chk_word("monitor syncs", em, n_mon);
         chk_word("half-band syncs", eh, n_hb);
         chk_word("oscillator syncs", eo, n_osc);
         rd(13'h100);
      end
      chk_byte("restart phase", {7'h0, ph_exp}, {7'h0, ph_seen});
      chk_word("reloaded phase", {mdl[35], mdl[34], 16'h0}, acc_seen);
      complete_run();
   end
endmodule
